// [core/pcpio_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_top #(
  parameter int PORT_NUM = pcpio_pkg::PORT_NUM
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Crossbar configuration
  input  wire logic [7:0]  crossbar_config_0,
  input  wire logic [7:0]  crossbar_config_1,
  input  wire logic [7:0]  crossbar_config_2,
  input  wire logic        spi_three_wire,
  input  wire logic        first_uart_mode0,
  input  wire logic        second_uart_mode0,
  // Port register write
  input  wire logic        reg_wr_en,
  input  wire logic        reg_wr_mode,
  input  wire logic [1:0]  reg_wr_port,
  input  wire logic        reg_wr_bit_en,
  input  wire logic [2:0]  reg_wr_bit,
  input  wire logic [7:0]  reg_wr_data,
  // Port register read
  input  wire logic        reg_rd_en,
  input  wire logic        reg_rd_rmw,
  input  wire logic [1:0]  reg_rd_port,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_rd_valid,
  // Peripheral side
  input  wire logic [29:0] periph_out,
  input  wire logic [29:0] periph_oe,
  output logic      [29:0] periph_in,
  // External memory interface
  input  wire logic        emif_on_low,
  input  wire logic        external_move_instruction_active,
  input  wire logic [31:0] emif_out,
  input  wire logic [31:0] emif_oe,
  // Port pins
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  // Status
  output logic      [31:0] pin_allocated,
  output logic      [31:0] port_data_latch,
  output logic      [31:0] port_output_mode_select
);
  // Pin p is bit p%8 of port p/8
  // The map itself is pure logic
  // Every pin decision is registered
  // That costs one cycle per change
  // but keeps map glitches off pads
  // Config, peripheral and memory
  // inputs share this clock
  // Only raw pin levels cross in
  localparam int PW = pcpio_pkg::PORT_W;
  localparam int NP = pcpio_pkg::PIN_NUM;
  localparam int NS = pcpio_pkg::SLOT_NUM;

  // Only the four lower ports are mapped by the crossbar
  // Another count needs a wider map
  // and more slots
  if (PORT_NUM * PW != NP) begin : g_chk
    $error("pcpio_top: PORT_NUM must give exactly 32 pins");
  end

  // Bit and byte writes share one
  // merge path; masked-out lanes
  // keep their stored value
  // Byte lane mask for a byte or a single bit write
  function automatic logic [7:0] lane_mask(input logic bit_en, input logic [2:0] idx);
    lane_mask = bit_en ? (8'h01 << idx) : 8'hFF;
  endfunction

  // Merge write data into one stored byte
  // Used by latches and mode bits
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] mask,
                                            input logic [7:0] val);
    merge_byte = (old & ~mask) | (val & mask);
  endfunction

  // The decoder fills both views
  // Pin view: owner of each pin
  // Slot view: pin of each slot
  pcpio_map_if map ();                    // Crossbar map carrier

  // Port registers
  logic [NP-1:0]  data_ff;                // Port data latches
  logic [NP-1:0]  mode_ff;                // Output mode bits, 1 is push-pull
  logic [NP-1:0]  nxt_data;               // Next data latches
  logic [NP-1:0]  nxt_mode;               // Next mode bits

  // Pin side
  logic [NP-1:0]  pin_lvl;                // Filtered pin levels
  logic [NP-1:0]  pin_out_ff;             // Registered pin value
  logic [NP-1:0]  pin_oe_ff;              // Registered pin enable
  logic [NP-1:0]  nxt_pin_out;            // Next pin value
  logic [NP-1:0]  nxt_pin_oe;             // Next pin enable

  // Crossbar side
  logic [NP-1:0]  alloc_ff;               // Registered allocation map
  logic [NS-1:0]  periph_in_ff;           // Registered peripheral inputs
  logic [NS-1:0]  nxt_periph_in;          // Next peripheral inputs

  // Read answer state
  logic [7:0]     rd_data_ff;             // Read answer
  logic           rd_valid_ff;            // Read answer strobe
  logic [7:0]     nxt_rd_data;            // Next read answer

  // Write and read decode
  logic [7:0]     wr_mask;                // Lanes touched by a write
  logic [7:0]     wr_val;                 // Value written to those lanes
  logic [7:0]     rd_pin_byte;            // Pin byte of the read port
  logic [7:0]     rd_latch_byte;          // Latch byte of the read port

  // Slot vectors
  logic [NP-1:0]  pout_pad;               // Peripheral values, widened
  logic [NP-1:0]  poe_pad;                // Peripheral enables, widened
  logic [NP-1:0]  in_mask_pad;            // Input slot mask, widened

  // Ownership controls
  logic           global_en;              // Global driver enable
  logic           emif_drive;             // External memory owns pins

  // Map follows config at once
  // A change while drivers are on
  // can move a peripheral between
  // pins from one cycle to the next
  // Settle config first, then raise
  // the global enable
  // Priority crossbar decoder
  pcpio_xbar_decode u_decode (
    .crossbar_config_0 (crossbar_config_0),
    .crossbar_config_1 (crossbar_config_1),
    .crossbar_config_2 (crossbar_config_2),
    .spi_three_wire    (spi_three_wire),
    .map               (map.decoder)
  );

  // Pins change at any time
  // Level follows four edges after
  // a pin settles; reads and inputs
  // of peripherals one edge later
  // A one-cycle spike is ignored
  // Pin input synchroniser
  pcpio_pin_sync #(
    .W (NP)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .raw_in  (pin_in),
    .level   (pin_lvl)
  );

  // Slot index is five bits wide
  // but only thirty slots exist;
  // the top two entries read low
  // Widen slot vectors so a pin slot index never leaves range
  assign pout_pad    = {2'b00, periph_out};
  assign poe_pad     = {2'b00, periph_oe};
  assign in_mask_pad = {2'b00, pcpio_pkg::SLOT_IN_MASK};

  // Global enable low holds every
  // driver off, whatever the map,
  // latches or memory ask for
  // global driver gate
  assign global_en  = crossbar_config_2[pcpio_pkg::C2_GLOBAL_EN];
  // During an off-chip move the
  // memory interface owns value and
  // enable of every pin
  // Only low-port placement is served
  // external memory takeover
  assign emif_drive = emif_on_low & external_move_instruction_active;

  // A bit write repeats its value
  // on all lanes; the mask picks
  // the one lane that changes
  // Write lane decode, a bit write takes its value from data bit 0
  assign wr_mask = lane_mask(reg_wr_bit_en, reg_wr_bit);
  assign wr_val  = reg_wr_bit_en ? {8{reg_wr_data[0]}} : reg_wr_data;

  // Each port matches its own index
  // Writes to peripheral pins still
  // land in the latch and show once
  // the pin returns to general use
  // Per port register update
  for (genvar q = 0; q < PORT_NUM; q++) begin : g_port
    wire logic hit_data;                  // Write aimed at this data latch
    wire logic hit_mode;                  // Write aimed at this mode register
    // Port select, data or mode
    assign hit_data = reg_wr_en & ~reg_wr_mode & (reg_wr_port == 2'(q));
    assign hit_mode = reg_wr_en &  reg_wr_mode & (reg_wr_port == 2'(q));
    assign nxt_data[q*PW +: PW] = hit_data ?
      merge_byte(data_ff[q*PW +: PW], wr_mask, wr_val) : data_ff[q*PW +: PW];
    assign nxt_mode[q*PW +: PW] = hit_mode ?
      merge_byte(mode_ff[q*PW +: PW], wr_mask, wr_val) : mode_ff[q*PW +: PW];
  end

  // Owner order: memory interface,
  // then crossbar slot, then latch
  // A listening owner gets no driver
  // Open-drain drives low only and
  // releases high to the pull-up
  // Forced open-drain slots ignore
  // the mode bit of their pin
  // Mode changes the enable only
  // Per pin output decision
  for (genvar p = 0; p < NP; p++) begin : g_pin
    wire logic       alloc;               // Pin owned by a peripheral
    wire logic [4:0] slot;                // Owning slot
    wire logic       rx_m0;               // Receive pin in shift mode
    wire logic       inp_only;            // Owner only listens
    wire logic       force_od;            // Owner forces open-drain
    wire logic       val;                 // Value to present
    wire logic       want;                // Owner wants to drive
    wire logic       od;                  // Effective open-drain
    // Owner lookup from the map
    assign alloc = map.sel_valid[p];
    assign slot  = map.sel_slot[p];
    // Shift-mode receive also sends
    assign rx_m0 = (first_uart_mode0  && slot == 5'(pcpio_pkg::SLOT_FIRST_UART_RX)) ||
                   (second_uart_mode0 && slot == 5'(pcpio_pkg::SLOT_SECOND_UART_RX));
    assign inp_only = alloc & in_mask_pad[slot] & ~rx_m0;
    assign force_od = alloc & (rx_m0 ||
                      slot == 5'(pcpio_pkg::SLOT_I2C_DATA) ||
                      slot == 5'(pcpio_pkg::SLOT_I2C_CLOCK));
    assign val  = alloc ? pout_pad[slot] : data_ff[p];
    assign want = alloc ? (poe_pad[slot] & ~inp_only) : 1'b1;
    assign od   = force_od | ~mode_ff[p];
    // Memory first, then owner, gated
    // push-pull drives high
    assign nxt_pin_oe[p]  = global_en & (emif_drive ? emif_oe[p] : (want & (~val | ~od)));
    assign nxt_pin_out[p] = emif_drive ? emif_out[p] : val;
  end

  // A disabled slot reads zero, so
  // no stale level reaches a
  // peripheral that lost its pins
  // An enabled slot reads its pin
  // even while that pin is driven
  // Route each enabled slot to its pin level
  for (genvar s = 0; s < NS; s++) begin : g_slot
    assign nxt_periph_in[s] = map.slot_en[s] & pin_lvl[map.slot_pin[s]];
  end

  // Ordinary reads show the port's
  // filtered pin level
  // Read-modify-write shows the latch
  // so a pin held low from outside
  // does not clear its latch bit
  // Read path byte selection
  assign rd_pin_byte   = pin_lvl[reg_rd_port*PW +: PW];
  assign rd_latch_byte = data_ff[reg_rd_port*PW +: PW];
  assign nxt_rd_data   = reg_rd_rmw ? rd_latch_byte : rd_pin_byte;

  // Port data latches and mode bits
  // Latches reset high: pins released
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_ff <= {PORT_NUM{pcpio_pkg::MODE_RST}};
      data_ff <= {PORT_NUM{pcpio_pkg::DATA_RST}};
    end else begin
      // Take the merged write result
      mode_ff <= nxt_mode;
      data_ff <= nxt_data;
    end
  end

  // Pin drivers and peripheral inputs
  // Reset holds every driver off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Drivers off, slots read zero
      pin_out_ff   <= '0;
      pin_oe_ff    <= '0;
      alloc_ff     <= '0;
      periph_in_ff <= '0;
    end else begin
      // Take the decided pin state
      pin_out_ff   <= nxt_pin_out;
      pin_oe_ff    <= nxt_pin_oe;
      alloc_ff     <= map.sel_valid;
      periph_in_ff <= nxt_periph_in;
    end
  end

  // Read answer, one cycle after the request
  // Strobe lasts one cycle, data holds
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // No answer pending after reset
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      // Strobe follows every request
      rd_valid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        // Capture the selected byte
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // Each output is a flip-flop:
  // no path through this block
  // Registered outputs
  // Pin drivers
  assign pin_out                 = pin_out_ff;
  assign pin_oe                  = pin_oe_ff;
  // Peripheral inputs and map
  assign periph_in               = periph_in_ff;
  assign pin_allocated           = alloc_ff;
  // Register contents and answer
  assign port_data_latch         = data_ff;
  assign port_output_mode_select = mode_ff;
  assign reg_rd_data             = rd_data_ff;
  assign reg_rd_valid            = rd_valid_ff;
endmodule
`default_nettype wire

// [core/pcpio_pkg.sv]
package pcpio_pkg;
  // Port geometry
  localparam int PORT_NUM = 4;
  localparam int PORT_W   = 8;
  localparam int PIN_NUM  = 32;
  localparam int IDX_W    = 5;
  localparam int SLOT_NUM = 30;
  // Crossbar slots in priority order, highest first
  localparam int SLOT_FIRST_UART_TX   = 0;
  localparam int SLOT_FIRST_UART_RX   = 1;
  localparam int SLOT_SPI_SCK         = 2;
  localparam int SLOT_SPI_SEL         = 5;
  localparam int SLOT_I2C_DATA        = 6;
  localparam int SLOT_I2C_CLOCK       = 7;
  localparam int SLOT_SECOND_UART_TX  = 8;
  localparam int SLOT_SECOND_UART_RX  = 9;
  localparam int SLOT_PCA_CEX0        = 10;
  localparam int PCA_CEX_NUM          = 6;
  // Slots that are pure peripheral inputs
  localparam logic [SLOT_NUM-1:0] SLOT_IN_MASK = 30'h37F90202;
  // Field positions of crossbar_config_0
  localparam int C0_I2C_EN     = 0;
  localparam int C0_SPI_EN     = 1;
  localparam int C0_FIRST_UART = 2;
  localparam int C0_PCA_LSB    = 3;
  localparam int C0_PCA_MSB    = 5;
  localparam int C0_ECI_EN     = 6;
  localparam int C0_CP0_EN     = 7;
  // Field positions of crossbar_config_1
  localparam int C1_CP1_EN     = 0;
  localparam int C1_T2EX_EN    = 6;
  localparam int C1_SYSCLK_EN  = 7;
  // Field positions of crossbar_config_2
  localparam int C2_CNVSTR0_EN = 0;
  localparam int C2_T4EX_EN    = 1;
  localparam int C2_SECOND_UART = 2;
  localparam int C2_T4_EN      = 3;
  localparam int C2_GLOBAL_EN  = 4;
  localparam int C2_CONVERTER_START_STROBE_TWO_EN = 6;
  // Reset values of the port registers
  localparam logic [PORT_W-1:0] DATA_RST = 8'hFF;
  localparam logic [PORT_W-1:0] MODE_RST = 8'h00;
endpackage

// [core/pcpio_map_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pcpio_map_if;
  // Pin side of the map: owner slot of each pin
  logic [pcpio_pkg::PIN_NUM-1:0]                        sel_valid;
  logic [pcpio_pkg::PIN_NUM-1:0][pcpio_pkg::IDX_W-1:0]  sel_slot;
  // Slot side of the map: pin of each enabled slot
  logic [pcpio_pkg::SLOT_NUM-1:0]                       slot_en;
  logic [pcpio_pkg::SLOT_NUM-1:0][pcpio_pkg::IDX_W-1:0] slot_pin;
  modport decoder (output sel_valid, sel_slot, slot_en, slot_pin);
  modport user    (input sel_valid, sel_slot, slot_en, slot_pin);
endinterface
`default_nettype wire

// [core/pcpio_xbar_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_xbar_decode (
  // Crossbar configuration
  input  wire logic [7:0] crossbar_config_0,
  input  wire logic [7:0] crossbar_config_1,
  input  wire logic [7:0] crossbar_config_2,
  input  wire logic       spi_three_wire,
  // Resulting pin map
  pcpio_map_if.decoder    map
);
  logic [2:0] pca_cnt;   // Number of capture outputs requested
  logic [5:0] cex_en;    // Per capture output enable
  logic [5:0] cnt;       // Next free pin
  logic       spi_en;    // Serial peripheral interface enable
  logic       i2c_en;    // Two-wire bus enable

  assign pca_cnt = crossbar_config_0[pcpio_pkg::C0_PCA_MSB:pcpio_pkg::C0_PCA_LSB];
  assign spi_en  = crossbar_config_0[pcpio_pkg::C0_SPI_EN];
  assign i2c_en  = crossbar_config_0[pcpio_pkg::C0_I2C_EN];
  for (genvar k = 0; k < pcpio_pkg::PCA_CEX_NUM; k++) begin : g_cex
    assign cex_en[k] = (pca_cnt > 3'(k));
  end

  assign map.slot_en = {
    crossbar_config_2[pcpio_pkg::C2_CONVERTER_START_STROBE_TWO_EN],
    crossbar_config_2[pcpio_pkg::C2_CNVSTR0_EN],
    crossbar_config_1[pcpio_pkg::C1_SYSCLK_EN],
    crossbar_config_2[pcpio_pkg::C2_T4EX_EN],
    crossbar_config_2[pcpio_pkg::C2_T4_EN],
    crossbar_config_1[pcpio_pkg::C1_T2EX_EN:pcpio_pkg::C1_CP1_EN],
    crossbar_config_0[pcpio_pkg::C0_CP0_EN],
    crossbar_config_0[pcpio_pkg::C0_ECI_EN],
    cex_en,
    {2{crossbar_config_2[pcpio_pkg::C2_SECOND_UART]}},
    {2{i2c_en}},
    spi_en & ~spi_three_wire,
    {3{spi_en}},
    {2{crossbar_config_0[pcpio_pkg::C0_FIRST_UART]}}};

  // Walk slots in priority order, handing out pins from the lowest
  // sequential priority allocation
  always_comb begin
    cnt           = 6'h00;
    map.sel_valid = '0;
    map.sel_slot  = '0;
    map.slot_pin  = '0;
    for (int s = 0; s < pcpio_pkg::SLOT_NUM; s++) begin
      map.slot_pin[s] = cnt[4:0];
      if (map.slot_en[s]) begin
        map.sel_valid[cnt[4:0]] = 1'b1;
        map.sel_slot[cnt[4:0]]  = 5'(s);
        cnt = cnt + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [core/pcpio_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_pin_sync #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Raw and filtered levels
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] level
);
  logic [W-1:0] stage1_ff;  // First capture, read only by stage 2
  logic [W-1:0] stage2_ff;  // Second stage
  logic [W-1:0] stage3_ff;  // Third stage
  logic [W-1:0] level_ff;   // Accepted level
  logic [W-1:0] nxt_level;  // Take a bit once stages 2 and 3 agree

  if (W < 1) begin : g_chk
    $error("pcpio_pin_sync: W must be positive");
  end

  assign nxt_level = (stage2_ff & stage3_ff) | (level_ff & (stage2_ff | stage3_ff));
  assign level     = level_ff;

  // Three stage chain with agreement filter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff  <= '0;
    end else begin
      stage1_ff <= raw_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end
endmodule
`default_nettype wire

// [bench/pcpio_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_pins_model (
  // Device side of each wire
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  // Far-end drivers
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_oe,
  // Resolved wire level
  output logic      [31:0] pin_in
);
  // released wire high
  // Device drive wins, then far end, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule
`default_nettype wire

// [bench/pcpio_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_top_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Configuration
  input wire logic [7:0]  crossbar_config_0,
  input wire logic [7:0]  crossbar_config_1,
  input wire logic [7:0]  crossbar_config_2,
  input wire logic        first_uart_mode0,
  // Register access
  input wire logic        reg_wr_en,
  input wire logic        reg_wr_mode,
  input wire logic [1:0]  reg_wr_port,
  input wire logic        reg_wr_bit_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_rd_en,
  input wire logic        reg_rd_rmw,
  input wire logic [1:0]  reg_rd_port,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        reg_rd_valid,
  // Memory interface and pins
  input wire logic        emif_on_low,
  input wire logic        external_move_instruction_active,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_allocated,
  input wire logic [31:0] port_data_latch,
  input wire logic [31:0] port_output_mode_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Memory interface owns the pins
  wire emif_own = emif_on_low & external_move_instruction_active;
  // Read request and its read-modify-write form
  sequence s_rd;
    reg_rd_en;
  endsequence
  sequence s_rd_rmw;
    s_rd ##0 reg_rd_rmw;
  endsequence
  property p_rst_mode;
    $rose(rst_n) |-> port_output_mode_select == 32'h0 && pin_oe == 32'h0;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode or drive not clear");
  property p_gate;
    $past(rst_n && !crossbar_config_2[4]) |-> pin_oe == 32'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("driver on while gated");
  property p_uart;
    $past(rst_n && crossbar_config_0[2]) |-> pin_allocated[1:0] == 2'h3;
  endproperty
  a_uart: assert property (p_uart) else $error("uart pins not at bottom");
  property p_none;
    $past(rst_n && {crossbar_config_0, crossbar_config_1, crossbar_config_2[3:0],
      crossbar_config_2[6]} == 21'h0) |-> pin_allocated == 32'h0;
  endproperty
  a_none: assert property (p_none) else $error("pin held with no enable");
  property p_rx_off;
    $past(rst_n && crossbar_config_0[2] && !first_uart_mode0 && !emif_own) |-> !pin_oe[1];
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive pin driven");
  property p_od;
    $past(rst_n && !emif_own) |-> (pin_oe & pin_out & ~$past(port_output_mode_select)) == 0;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  property p_rd;
    s_rd |=> reg_rd_valid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_rmw;
    s_rd_rmw |=> reg_rd_data == $past(port_data_latch[reg_rd_port*8 +: 8]);
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw read not latch");
  property p_wr;
    reg_wr_en && !reg_wr_mode && !reg_wr_bit_en |=>
      port_data_latch[$past(reg_wr_port)*8 +: 8] == $past(reg_wr_data);
  endproperty
  a_wr: assert property (p_wr) else $error("byte write lost");
  property p_pp;
    $past(rst_n && crossbar_config_2 == 8'h10 && crossbar_config_0 == 8'h0 && !emif_own
      && crossbar_config_1 == 8'h0 && port_output_mode_select[0])
      |-> pin_oe[0] && pin_out[0] == $past(port_data_latch[0]);
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin wrong");
endmodule
bind pcpio_top pcpio_top_chk i_chk (.*);
`default_nettype wire

// [bench/pcpio_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pcpio_top_tb;
  // Clock, reset and tallies
  logic ref_clk, rst_n;
  int   fail_count, checks_done;
  // Stimulus
  logic [7:0]  c0, c1, c2, wr_data;
  logic        spi_3w, wr_en, wr_mode, wr_bit_en, rd_en, rd_rmw, emif_low, external_move_instruction;
  logic [1:0]  wr_port, rd_port, uart_m0;
  logic [2:0]  wr_bit;
  logic [29:0] p_out, p_oe;
  logic [31:0] e_out, e_oe, ext_val, ext_oe;
  // Observed
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [29:0] periph_in;
  logic [31:0] pin_in, pin_out, pin_oe, alloc, latch, mode;
  pcpio_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .crossbar_config_0(c0),
    .crossbar_config_1(c1), .crossbar_config_2(c2), .spi_three_wire(spi_3w),
    .first_uart_mode0(uart_m0[0]), .second_uart_mode0(uart_m0[1]), .reg_wr_en(wr_en),
    .reg_wr_mode(wr_mode), .reg_wr_port(wr_port), .reg_wr_bit_en(wr_bit_en),
    .reg_wr_bit(wr_bit), .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_rmw(rd_rmw),
    .reg_rd_port(rd_port), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
    .periph_out(p_out), .periph_oe(p_oe), .periph_in(periph_in), .emif_on_low(emif_low),
    .external_move_instruction_active(external_move_instruction), .emif_out(e_out), .emif_oe(e_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_allocated(alloc), .port_data_latch(latch),
    .port_output_mode_select(mode));
  pcpio_pins_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));
  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Step to just after a rising edge
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // One register write, then a quiet cycle
  task automatic wr(logic md, logic [1:0] pt, logic be, logic [2:0] b, logic [7:0] d);
    {wr_en, wr_mode, wr_port, wr_bit_en, wr_bit, wr_data} = {1'b1, md, pt, be, b, d};
    tick();
    wr_en = 1'b0;
    tick();
  endtask
  // One read, answer judged in the pulse cycle
  task automatic rd(logic rmw, logic [1:0] pt, logic [7:0] exp);
    {rd_en, rd_rmw, rd_port} = {1'b1, rmw, pt};
    tick();
    rd_en = 1'b0;
    chk(32'h1, {31'h0, rd_valid});
    chk({24'h0, exp}, {24'h0, rd_data});
    tick();
  endtask
  task automatic cfg(logic [7:0] a, logic [7:0] b, logic [7:0] g);
    {c0, c1, c2} = {a, b, g};
    tick(2);
  endtask
  // Reset held five cycles, checked while held
  task automatic t_reset();
    rst_n = 1'b0;
    tick(5);
    chk(32'h0, mode);
    chk(32'h0, pin_oe);
    rst_n = 1'b1;
    tick();
  endtask
  task automatic t_gpio();
    wr(1'b1, 2'h0, 1'b0, 3'h0, 8'hFF);
    wr(1'b0, 2'h0, 1'b0, 3'h0, 8'h0F);
    chk(32'h0, pin_oe);
    cfg(8'h00, 8'h00, 8'h10);
    chk(32'hFF, pin_oe & 32'hFF);
    chk(32'h0F, pin_out & 32'hFF);
    wr(1'b1, 2'h0, 1'b0, 3'h0, 8'h00);
    wr(1'b0, 2'h0, 1'b1, 3'h7, 8'h01);
    chk(32'h8F, latch & 32'hFF);
    chk(32'h70, pin_oe & 32'hFF);
    ext_oe = 32'h1;
    tick(6);
    rd(1'b0, 2'h0, 8'h8E);
    rd(1'b1, 2'h0, 8'h8F);
  endtask
  task automatic t_uart();
    ext_oe = 32'h2;
    wr(1'b1, 2'h0, 1'b0, 3'h0, 8'hFF);
    cfg(8'h04, 8'h00, 8'h10);
    p_oe = 30'h1;
    tick(6);
    chk(32'h3, alloc & 32'h3);
    chk(32'h1, pin_oe & 32'h3);
    chk(32'h0, pin_out & 32'h1);
    chk(32'h0, {31'h0, periph_in[1]});
    p_out = 30'h1;
    ext_oe = 32'h0;
    tick(6);
    chk(32'h1, pin_out & 32'h1);
    chk(32'h1, {31'h0, periph_in[1]});
    cfg(8'h01, 8'h00, 8'h10);
    {p_oe, p_out} = {30'hC0, 30'h40};
    tick(2);
    chk(32'h2, pin_oe & 32'h3);
    // Shift-mode receive pins may drive, low only
    uart_m0 = 2'h3;
    cfg(8'h04, 8'h00, 8'h14);
    {p_oe, p_out} = {30'h202, 30'h0};
    tick(2);
    chk(32'hA, pin_oe & 32'hF);
    p_out = 30'h202;
    tick(2);
    chk(32'h0, pin_oe & 32'hF);
    {uart_m0, p_oe, p_out} = '0;
  endtask
  // Enable sets against expected allocation: {c0, c1, c2, pins}
  task automatic t_alloc();
    logic [31:0] tab [10] = '{32'h04001003, 32'h0200100F, 32'h0600103F, 32'h01001003,
      32'h18001007, 32'h3800103F, 32'h00801001, 32'h00001403, 32'h00005407, 32'h00001000};
    foreach (tab[i]) begin
      cfg(tab[i][31:24], tab[i][23:16], tab[i][15:8]);
      chk({24'h0, tab[i][7:0]}, alloc);
    end
    spi_3w = 1'b1;
    cfg(8'h06, 8'h00, 8'h10);
    chk(32'h1F, alloc);
    spi_3w = 1'b0;
  endtask
  task automatic t_emif();
    for (int p = 0; p < 4; p++) begin
      wr(1'b1, p[1:0], 1'b0, 3'h0, 8'hFF);
    end
    {emif_low, external_move_instruction, e_out, e_oe} = {2'h3, 32'hA5A5A5A5, 32'hFFFF00FF};
    tick(2);
    chk(e_oe, pin_oe);
    chk(e_out & e_oe, pin_out & e_oe);
    external_move_instruction = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    fail_count = 0;
    checks_done = 0;
    {c0, c1, c2, spi_3w, wr_en, wr_mode, wr_port, wr_bit_en, wr_bit, wr_data} = '0;
    {rd_en, rd_rmw, rd_port, p_out, p_oe, emif_low, external_move_instruction, e_out, e_oe, ext_val, ext_oe} = '0;
    uart_m0 = 2'h0;
    t_reset();
    t_gpio();
    t_uart();
    t_alloc();
    t_emif();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
